// File: inc/clock_system_pkg.sv
// constants, fuse layout and types for the clock source and prescaler block
package clock_system_pkg;
  localparam int CLK_MHZ = 200;
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] ADDR_TRIM = 4'h0;
  localparam logic [3:0] ADDR_PRESCALE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int TRIM_RANGE_BIT = 7;
  localparam int PCE_BIT = 7;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_EXTERNAL = 4'h0;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_RC = 4'h2;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_LOW_POWER = 4'h3;
  localparam logic [1:0] SUT_BOD = 2'h0;
  localparam logic [1:0] SUT_FAST = 2'h1;
  localparam logic [1:0] SUT_SLOW = 2'h2;
  localparam logic [1:0] SUT_SHIPPED = SUT_SLOW;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_SHIPPED = CLOCK_SOURCE_SELECT_RC;
  localparam logic [3:0] PS_RESET_NODIV = 4'h0;
  localparam logic [3:0] PS_RESET_DIV8 = 4'h3;
  localparam logic [3:0] PS_MAX = 4'h8;
  localparam logic [2:0] CHANGE_WINDOW = 3'h4;
  localparam logic [31:0] CYC_BASE = 32'h0000000E;
  localparam logic [2:0] CYC_WAKE = 3'h6;
  // additional reset delays in microseconds
  localparam int T_FAST_US = 4100;
  localparam int T_SLOW_US = 65000;
  localparam int T_LP_FAST_US = 4000;
  localparam int T_LP_SLOW_US = 64000;
  localparam int CYC_FAST = T_FAST_US * CLK_MHZ;
  localparam int CYC_SLOW = T_SLOW_US * CLK_MHZ;
  localparam int CYC_LP_FAST = T_LP_FAST_US * CLK_MHZ;
  localparam int CYC_LP_SLOW = T_LP_SLOW_US * CLK_MHZ;

  // fuse bits: 1 means programmed
  typedef struct packed {
    logic [3:0] clock_source_select;
    logic [1:0] startup_time_select;
    logic clock_output_fuse;
    logic divide_by_eight_fuse;
    logic reset_pin_disable_fuse;
  } fuse_t;

  localparam fuse_t FUSE_SHIPPED = '{CLOCK_SOURCE_SELECT_SHIPPED, SUT_SHIPPED, 1'b0, 1'b1, 1'b0};

  typedef enum logic [1:0] {SRC_EXTERNAL, SRC_RC, SRC_LOW_POWER, SRC_OTHER} source_t;
  typedef enum logic [1:0] {ST_LOAD, ST_COUNT, ST_RUN} start_state_t;
endpackage

// File: verilog/system_clock_source_and_prescaler.sv
// clock source decode, start-up delay, rc trim and glitch-free system prescaler
`timescale 1ns/1ps
`default_nettype none

module system_clock_source_and_prescaler #(
  parameter int unsigned DELAY_FAST_CYCLES = clock_system_pkg::CYC_FAST,
  parameter int unsigned DELAY_SLOW_CYCLES = clock_system_pkg::CYC_SLOW,
  parameter int unsigned DELAY_LP_FAST_CYCLES = clock_system_pkg::CYC_LP_FAST,
  parameter int unsigned DELAY_LP_SLOW_CYCLES = clock_system_pkg::CYC_LP_SLOW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire clock_system_pkg::fuse_t fuses,
  input wire logic fuses_blank,
  input wire logic [7:0] factory_trim,
  input wire logic wake_request,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [clock_system_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output var logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output var logic bvalid,
  input wire logic bready,
  output var logic [1:0] bresp,
  input wire logic arvalid,
  output var logic arready,
  input wire logic [clock_system_pkg::AXI_ADDR_W-1:0] araddr,
  output var logic rvalid,
  input wire logic rready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic core_reset_n,
  output var logic wake_ready,
  output var logic system_clock_tick,
  output var logic clock_output_pin_o,
  output var logic clock_output_pin_oe_n,
  output var logic [7:0] rc_trim_code,
  output var clock_system_pkg::source_t source_select,
  output var logic timer_osc_enable
);
  import clock_system_pkg::*;

  function automatic logic [7:0] div_last_of(input logic [3:0] sel);
    // reserved codes divide like the largest factor
    if (sel > PS_MAX) begin
      div_last_of = 8'hFF;
    end else begin
      div_last_of = 8'((9'h001 << sel) - 9'h001);
    end
  endfunction

  // blank fuses take the shipped defaults
  fuse_t eff;
  assign eff = fuses_blank ? FUSE_SHIPPED : fuses;

  source_t src_next;
  assign src_next = (eff.clock_source_select == CLOCK_SOURCE_SELECT_EXTERNAL) ? SRC_EXTERNAL :
                    (eff.clock_source_select == CLOCK_SOURCE_SELECT_RC) ? SRC_RC :
                    (eff.clock_source_select == CLOCK_SOURCE_SELECT_LOW_POWER) ? SRC_LOW_POWER : SRC_OTHER;

  // additional reset delay by startup code and source
  logic [31:0] extra_cycles;
  always_comb begin
    case (eff.startup_time_select)
      // reset pin disabled needs time to enter programming mode
      SUT_BOD: extra_cycles = eff.reset_pin_disable_fuse ? 32'(DELAY_FAST_CYCLES) : 32'h0;
      // low-power source uses its own figures
      SUT_FAST: extra_cycles = (src_next == SRC_LOW_POWER) ? 32'(DELAY_LP_FAST_CYCLES)
                                                           : 32'(DELAY_FAST_CYCLES);
      SUT_SLOW: extra_cycles = (src_next == SRC_LOW_POWER) ? 32'(DELAY_LP_SLOW_CYCLES)
                                                           : 32'(DELAY_SLOW_CYCLES);
      default: extra_cycles = 32'h0;
    endcase
  end
  wire [31:0] startup_total = CYC_BASE + extra_cycles;

  // start-up hold of the core after reset release
  start_state_t st_reg;
  logic [31:0] st_cnt_reg;
  // hold core reset for 14 cycles plus the selected delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_LOAD;
      st_cnt_reg <= 32'h0;
      core_reset_n <= 1'b0;
    end else begin
      case (st_reg)
        ST_LOAD: begin
          st_reg <= ST_COUNT;
          st_cnt_reg <= startup_total - 32'h2;
        end
        ST_COUNT: begin
          if (st_cnt_reg == 32'h0) begin
            st_reg <= ST_RUN;
            core_reset_n <= 1'b1;
          end else begin
            st_cnt_reg <= st_cnt_reg - 32'h1;
          end
        end
        ST_RUN: core_reset_n <= 1'b1;
        default: st_reg <= ST_LOAD;
      endcase
    end
  end

  // wake-up from power-down or power-save
  logic [2:0] wake_cnt_reg;
  wire wake_start = wake_request && (st_reg == ST_RUN) && (wake_cnt_reg == 3'h0);
  // six cycles from wake request to ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt_reg <= 3'h0;
      wake_ready <= 1'b0;
    end else begin
      wake_ready <= (wake_cnt_reg == 3'h1);
      if (wake_start) begin
        wake_cnt_reg <= CYC_WAKE - 3'h1;
      end else if (wake_cnt_reg != 3'h0) begin
        wake_cnt_reg <= wake_cnt_reg - 3'h1;
      end
    end
  end

  // bus write and read handshakes
  logic wr_rdy_reg;
  logic rd_rdy_reg;
  wire wr_start = awvalid && wvalid && !wr_rdy_reg && !bvalid;
  wire wr_take = awvalid && wvalid && wr_rdy_reg;
  wire rd_start = arvalid && !rd_rdy_reg && !rvalid;
  wire rd_take = arvalid && rd_rdy_reg;
  wire wr_mapped = (awaddr == ADDR_TRIM) || (awaddr == ADDR_PRESCALE) ||
                   (awaddr == ADDR_STATUS);
  wire rd_mapped = (araddr == ADDR_TRIM) || (araddr == ADDR_PRESCALE) ||
                   (araddr == ADDR_STATUS);
  wire wr_trim = wr_take && wstrb[0] && (awaddr == ADDR_TRIM);
  wire wr_ps = wr_take && wstrb[0] && (awaddr == ADDR_PRESCALE);

  // prescaler change protection
  logic [2:0] win_cnt_reg;
  logic [3:0] ps_sel_reg;
  wire win_open = (win_cnt_reg != 3'h0);
  // enable only counts when every lower bit (6:0) is zero
  wire pce_write = wr_ps && wdata[PCE_BIT] && (wdata[PCE_BIT-1:0] == 7'h00);
  wire sel_write = wr_ps && !wdata[PCE_BIT] && win_open;
  wire [2:0] win_next = sel_write ? 3'h0 :
                        (pce_write && !win_open) ? CHANGE_WINDOW :
                        win_open ? win_cnt_reg - 3'h1 : 3'h0;
  wire [3:0] ps_reset_sel = eff.divide_by_eight_fuse ? PS_RESET_DIV8 : PS_RESET_NODIV;

  // rewrites during the window neither extend nor clear it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_cnt_reg <= 3'h0;
    end else begin
      win_cnt_reg <= win_next;
    end
  end

  // reset select follows the divide-by-8 fuse
  // select only changes inside the enable window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_sel_reg <= ps_reset_sel;
    end else if (sel_write) begin
      ps_sel_reg <= wdata[3:0];
    end
  end

  // divider; a new select is adopted only at the end of the old period,
  // so no period shorter than the old or new one is ever produced
  logic [3:0] active_sel_reg;
  logic [7:0] div_cnt_reg;
  wire [7:0] div_last = div_last_of(active_sel_reg);
  wire at_end = (div_cnt_reg == div_last);
  // glitch-free adoption at the period boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_sel_reg <= ps_reset_sel;
      div_cnt_reg <= 8'h00;
      system_clock_tick <= 1'b0;
    end else begin
      system_clock_tick <= at_end;
      div_cnt_reg <= at_end ? 8'h00 : div_cnt_reg + 8'h01;
      if (at_end) begin
        active_sel_reg <= ps_sel_reg;
      end
    end
  end

  // divided clock on the output pin, enable low while driving
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_output_pin_o <= 1'b0;
    end else begin
      clock_output_pin_o <= eff.clock_output_fuse && at_end;
    end
  end
  // pin enable ignores reset so the pin is owned during reset as well
  always_ff @(posedge aclk) begin
    clock_output_pin_oe_n <= !eff.clock_output_fuse;
  end

  // trim register: factory value at reset, then software
  logic [7:0] trim_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_reg <= factory_trim;
    end else if (wr_trim) begin
      trim_reg <= wdata[7:0];
    end
  end
  // range bit and fine bits go unchanged to the oscillator
  always_ff @(posedge aclk) begin
    rc_trim_code <= {trim_reg[TRIM_RANGE_BIT], trim_reg[TRIM_RANGE_BIT-1:0]};
  end

  // timer oscillator pins free only with an internal rc source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_select <= SRC_OTHER;
      timer_osc_enable <= 1'b0;
    end else begin
      source_select <= src_next;
      timer_osc_enable <= (src_next == SRC_RC) || (src_next == SRC_LOW_POWER);
    end
  end

  // register read data
  wire [31:0] status_word = {26'h0, timer_osc_enable, eff.startup_time_select,
                             source_select, core_reset_n};
  wire [31:0] rd_word = (araddr == ADDR_TRIM) ? {24'h0, trim_reg} :
                        (araddr == ADDR_PRESCALE) ? {24'h0, win_open, 3'h0, ps_sel_reg} :
                        (araddr == ADDR_STATUS) ? status_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_rdy_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      wr_rdy_reg <= wr_start;
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  assign awready = wr_rdy_reg;
  assign wready = wr_rdy_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_rdy_reg <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else begin
      rd_rdy_reg <= rd_start;
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_mapped ? 2'h0 : 2'h2;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  assign arready = rd_rdy_reg;

  // helper logic for the checks below
  logic [31:0] since_release_reg;
  logic [8:0] since_end_reg;
  logic [7:0] period_last_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_release_reg <= 32'h0;
      since_end_reg <= 9'h0;
      period_last_reg <= div_last_of(ps_reset_sel);
    end else begin
      since_release_reg <= since_release_reg + 32'h1;
      since_end_reg <= at_end ? 9'h0 : since_end_reg + 9'h1;
      if (at_end) begin
        period_last_reg <= div_last_of(ps_sel_reg);
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_startup_delay_len: assert property (
    $rose(core_reset_n) |-> since_release_reg == startup_total)
    else $error("core reset released at wrong cycle");

  a_wake_six_cycles: assert property (
    wake_start |=> !wake_ready [*5] ##1 wake_ready)
    else $error("wake ready not six cycles after request");

  a_pce_clean_only: assert property (
    wr_ps && wdata[PCE_BIT] && (wdata[6:0] != 7'h00) && !win_open |=> !win_open)
    else $error("enable opened by a write with other bits set");

  a_window_four_cycles: assert property (
    (pce_write && !win_open) ##1 (!sel_write) [*4] |=> !win_open)
    else $error("change window not closed after four cycles");

  a_window_stays_open: assert property (
    (pce_write && !win_open) ##1 (!sel_write) [*3] |=> win_open)
    else $error("change window closed early");

  a_sel_closes_window: assert property (
    sel_write |=> !win_open)
    else $error("change window still open after select write");

  a_sel_needs_window: assert property (
    !$stable(ps_sel_reg) |-> $past(win_open) && $past(wr_ps))
    else $error("select changed outside the change window");

  a_period_exact: assert property (
    at_end |-> since_end_reg[7:0] == period_last_reg && since_end_reg[8] == 1'b0)
    else $error("divided period length wrong");

  a_clkout_follows_tick: assert property (
    eff.clock_output_fuse |=> clock_output_pin_o == $past(at_end) && !clock_output_pin_oe_n)
    else $error("clock output pin not the divided clock");

  a_timer_osc_gate: assert property (
    timer_osc_enable |-> (source_select == SRC_RC) || (source_select == SRC_LOW_POWER))
    else $error("timer oscillator enabled with non rc source");

  a_reset_values: assert property (
    disable iff (1'b0) $rose(aresetn) |-> ps_sel_reg == $past(ps_reset_sel)
      && trim_reg == $past(factory_trim))
    else $error("wrong select or trim after reset");
endmodule

`default_nettype wire

// File: testbench/clock_domain_consumer.sv
// consumer model: measures divided clock periods and resolves the clock output pin
`timescale 1ns/1ps
`default_nettype none
module clock_domain_consumer (
  input wire logic aclk,
  input wire logic tick,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  input wire logic clear_min,
  output var logic pin_level,
  output var int tick_gap,
  output var int pin_gap,
  output var int min_gap
);
  int tick_cnt = 1;
  int pin_cnt = 1;
  logic pin_prev = 1'b0;
  // released pin floats
  // no pull on the pin, so a released pin flips every cycle instead of holding
  assign pin_level = pin_oe_n ? ~pin_prev : pin_o;
  always @(posedge aclk) begin
    pin_prev <= pin_level;
    tick_cnt <= (tick === 1'b1) ? 1 : tick_cnt + 1;
    pin_cnt <= (pin_level === 1'b1) ? 1 : pin_cnt + 1;
    if (tick === 1'b1) begin
      tick_gap <= tick_cnt;
    end
    if (pin_level === 1'b1) begin
      pin_gap <= pin_cnt;
    end
    if (clear_min) begin
      min_gap <= 1000;
    end else if (tick === 1'b1 && tick_cnt < min_gap) begin
      min_gap <= tick_cnt;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_system_clock_source_and_prescaler.sv
// self-checking bench for the clock source and prescaler block
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_and_prescaler;
  import clock_system_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  fuse_t fuses = '0;
  logic fuses_blank = 0;
  logic [7:0] factory_trim = 8'h5A;
  logic wake_request = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, clear_min = 0;
  // responses are always accepted at once
  logic bready = 1, rready = 1;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, core_reset_n, wake_ready, tick;
  logic pin_o, pin_oe_n, pin_level, timer_osc_enable;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, rd;
  logic [7:0] trim_code;
  source_t source_select;
  int tick_gap, pin_gap, min_gap, cyc, n, old_div;
  int errors = 0, checks_done = 0;
  logic [7:0] trims [4] = '{8'h7F, 8'h80, 8'h00, 8'hFF};
  int codes [10] = '{0, 8, 1, 7, 2, 6, 3, 5, 4, 0};

  system_clock_source_and_prescaler #(.DELAY_FAST_CYCLES(40), .DELAY_SLOW_CYCLES(80),
    .DELAY_LP_FAST_CYCLES(30), .DELAY_LP_SLOW_CYCLES(70)) uut (.aclk(aclk), .aresetn(aresetn),
    .fuses(fuses), .fuses_blank(fuses_blank), .factory_trim(factory_trim),
    .wake_request(wake_request), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .core_reset_n(core_reset_n), .wake_ready(wake_ready), .system_clock_tick(tick),
    .clock_output_pin_o(pin_o), .clock_output_pin_oe_n(pin_oe_n), .rc_trim_code(trim_code),
    .source_select(source_select), .timer_osc_enable(timer_osc_enable));

  clock_domain_consumer consumer (.aclk(aclk), .tick(tick), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .clear_min(clear_min), .pin_level(pin_level),
    .tick_gap(tick_gap), .pin_gap(pin_gap), .min_gap(min_gap));

  always #2.5 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // called right after an edge or between edges; valid rises by nonblocking assignment
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      k++;
    end while (!(awready === 1'b1 && wready === 1'b1) && k < 100);
    awvalid <= 0;
    wvalid <= 0;
    do begin
      @(posedge aclk);
      k++;
    end while (bvalid !== 1'b1 && k < 200);
    resp = bresp;
    if (k >= 200) errors++;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge aclk);
      k++;
    end while (arready !== 1'b1 && k < 100);
    arvalid <= 0;
    do begin
      @(posedge aclk);
      k++;
    end while (rvalid !== 1'b1 && k < 200);
    d = rdata;
    resp = rresp;
    if (k >= 200) errors++;
  endtask

  task automatic wait_ticks(input int cnt, output int cycles);
    int seen;
    seen = 0;
    cycles = 0;
    while (seen < cnt && cycles < 3000) begin
      @(posedge aclk);
      cycles++;
      if (tick === 1'b1) seen++;
    end
    if (cycles >= 3000) errors++;
    #1;
  endtask

  task automatic run_reset(input fuse_t f, input logic blank, input int extra);
    fuse_t e;
    source_t src;
    e = blank ? FUSE_SHIPPED : f;
    src = e.clock_source_select == CLOCK_SOURCE_SELECT_EXTERNAL ? SRC_EXTERNAL :
          e.clock_source_select == CLOCK_SOURCE_SELECT_RC ? SRC_RC :
          e.clock_source_select == CLOCK_SOURCE_SELECT_LOW_POWER ? SRC_LOW_POWER : SRC_OTHER;
    @(posedge aclk);
    aresetn <= 0;
    fuses <= f;
    fuses_blank <= blank;
    repeat (10) @(posedge aclk);
    #1;
    check(core_reset_n, 0);
    check(pin_oe_n, !e.clock_output_fuse);
    @(posedge aclk);
    aresetn <= 1;
    n = 0;
    while (core_reset_n !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    check(n, 15 + extra);
    axi_read(ADDR_TRIM, rd, r);
    check(rd, {24'h0, factory_trim});
    axi_read(ADDR_PRESCALE, rd, r);
    check(rd, e.divide_by_eight_fuse ? PS_RESET_DIV8 : PS_RESET_NODIV);
    check(source_select, src);
    // timer oscillator input is never externally clocked here
    check(timer_osc_enable, src == SRC_RC || src == SRC_LOW_POWER);
    axi_read(ADDR_STATUS, rd, r);
    check(rd, {26'h0, (src == SRC_RC || src == SRC_LOW_POWER), e.startup_time_select, src,
               1'b1});
  endtask

  task automatic change_ps(input logic [3:0] code, input int new_div);
    @(posedge aclk);
    clear_min <= 1;
    @(posedge aclk);
    clear_min <= 0;
    axi_write(ADDR_PRESCALE, 32'h80, 4'hF, r);
    axi_write(ADDR_PRESCALE, {28'h0, code}, 4'hF, r);
    wait_ticks(2, cyc);
    check(cyc <= old_div + new_div, 1);
    wait_ticks(1, cyc);
    check(tick_gap, new_div);
    check(pin_gap, new_div);
    check(min_gap >= (old_div < new_div ? old_div : new_div), 1);
    old_div = new_div;
  endtask

  initial begin
    #300000;
    errors++;
    conclude();
  end

  initial begin
    run_reset('{CLOCK_SOURCE_SELECT_RC, SUT_BOD, 1'b0, 1'b0, 1'b0}, 0, 0);
    run_reset('{CLOCK_SOURCE_SELECT_RC, SUT_FAST, 1'b0, 1'b0, 1'b0}, 0, 40);
    run_reset('{CLOCK_SOURCE_SELECT_RC, SUT_SLOW, 1'b0, 1'b1, 1'b0}, 0, 80);
    run_reset('{CLOCK_SOURCE_SELECT_RC, 2'h3, 1'b0, 1'b0, 1'b0}, 0, 0);
    run_reset('{CLOCK_SOURCE_SELECT_RC, SUT_BOD, 1'b0, 1'b0, 1'b1}, 0, 40);
    run_reset('{CLOCK_SOURCE_SELECT_LOW_POWER, SUT_FAST, 1'b0, 1'b0, 1'b0}, 0, 30);
    run_reset('{CLOCK_SOURCE_SELECT_LOW_POWER, SUT_SLOW, 1'b0, 1'b0, 1'b0}, 0, 70);
    run_reset('{CLOCK_SOURCE_SELECT_EXTERNAL, SUT_FAST, 1'b0, 1'b0, 1'b0}, 0, 40);
    run_reset('{CLOCK_SOURCE_SELECT_EXTERNAL, SUT_SLOW, 1'b1, 1'b0, 1'b0}, 0, 80);
    run_reset('{4'h7, SUT_BOD, 1'b0, 1'b0, 1'b0}, 0, 0);
    run_reset('0, 1, 80);
    run_reset('{CLOCK_SOURCE_SELECT_RC, SUT_BOD, 1'b1, 1'b1, 1'b0}, 0, 0);
    // no nonvolatile writes run, so the full trim span is legal
    foreach (trims[i]) begin
      axi_write(ADDR_TRIM, {24'h0, trims[i]}, 4'hF, r);
      check(r, 2'h0);
      axi_read(ADDR_TRIM, rd, r);
      check(rd, {24'h0, trims[i]});
      check(trim_code, trims[i]);
    end
    axi_write(ADDR_TRIM, 32'h11, 4'hE, r);
    axi_read(ADDR_TRIM, rd, r);
    check(rd, 32'h000000FF);
    axi_read(4'hC, rd, r);
    check(r, 2'h2);
    check(rd, 32'h0);
    axi_write(ADDR_STATUS, 32'h0, 4'hF, r);
    check(r, 2'h0);
    axi_write(4'hC, 32'h0, 4'hF, r);
    check(r, 2'h2);
    // start from the divide-by-8 reset setting
    old_div = 8;
    foreach (codes[i]) change_ps(codes[i][3:0], 1 << codes[i]);
    // reserved select divides like the largest factor and reads back
    change_ps(4'h9, 256);
    @(posedge aclk);
    axi_read(ADDR_PRESCALE, rd, r);
    check(rd, 32'h9);
    change_ps(4'h0, 1);
    @(posedge aclk);
    // enable with other bits set must not open the window
    axi_write(ADDR_PRESCALE, 32'h81, 4'hF, r);
    axi_write(ADDR_PRESCALE, 32'h05, 4'hF, r);
    axi_read(ADDR_PRESCALE, rd, r);
    check(rd, 32'h0);
    // window expires after four cycles
    axi_write(ADDR_PRESCALE, 32'h80, 4'hF, r);
    repeat (8) @(posedge aclk);
    axi_write(ADDR_PRESCALE, 32'h05, 4'hF, r);
    axi_read(ADDR_PRESCALE, rd, r);
    check(rd, 32'h0);
    // a second enable write must not stretch the window
    axi_write(ADDR_PRESCALE, 32'h80, 4'hF, r);
    axi_write(ADDR_PRESCALE, 32'h80, 4'hF, r);
    axi_write(ADDR_PRESCALE, 32'h05, 4'hF, r);
    axi_read(ADDR_PRESCALE, rd, r);
    check(rd, 32'h0);
    wait_ticks(2, cyc);
    check(tick_gap, 1);
    @(posedge aclk);
    wake_request <= 1;
    @(posedge aclk);
    wake_request <= 0;
    n = 0;
    while (wake_ready !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    check(n, 6);
    @(posedge aclk);
    check(wake_ready, 0);
    conclude();
  end
endmodule
`default_nettype wire
